//--- adc_irq_pkg.sv
// Package for the converter interrupt and result block.
// Assumes a 32-bit APB slave clocked by pclk.
package adc_irq_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CHAN_ENABLE = 8'h10; // Channel enable, WO
  localparam logic [7:0] OFF_CHAN_DISABLE = 8'h14; // Channel disable, WO
  localparam logic [7:0] OFF_CHAN_VIEW = 8'h18; // Channel status, RO
  localparam logic [7:0] OFF_STATUS = 8'h1C; // Converter status, RO
  localparam logic [7:0] OFF_LATEST = 8'h20; // Latest result, RO
  localparam logic [7:0] OFF_IRQ_SET = 8'h24; // Interrupt enable, WO
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h28; // Interrupt disable, WO
  localparam logic [7:0] OFF_IRQ_VIEW = 8'h2C; // Interrupt mask, RO
  localparam logic [7:0] OFF_MODE = 8'h04; // Mode: resolution select
  localparam logic [7:0] OFF_RESULT0 = 8'h30; // First channel result
  localparam logic [7:0] OFF_RESULT7 = 8'h4C; // Last channel result

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int NUM_CHAN = 8; // Analog channels
  localparam int NUM_SRC = 20; // Interrupt sources
  localparam int POS_DONE = 0; // Conversion-done bits 0..7
  localparam int POS_OVR = 8; // Channel overrun bits 8..15
  localparam int POS_RDY = 16; // Result available
  localparam int POS_GOVR = 17; // Global overrun
  localparam int POS_RXEND = 18; // Receive count end
  localparam int POS_RXFULL = 19; // Both counts empty
  localparam int POS_REDUCED_RESOLUTION_SEL = 4; // Resolution select in mode
  localparam int RES_WIDTH = 10; // Full result width
  localparam int RES_WIDTH_LOW = 8; // Reduced result width

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [19:0] RST_MASK = 20'h00000; // All sources off
  localparam logic [31:0] RST_WORD = 32'h00000000; // Zero word

endpackage : adc_irq_pkg

//--- adc_irq_mask.sv
// Interrupt mask register with set/clear write ports.
// Assumes one-cycle write strobes from the bus slave.
`timescale 1ns/1ps
module adc_irq_mask #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write strobes and data
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [WIDTH-1:0] wdata,
  // Sources and mask view
  input wire logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  import adc_irq_pkg::*;

  // ----------------------------------------
  // Mask storage
  // ----------------------------------------
  // Set and clear ports only touch bits written as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= RST_MASK;
    end else if (set_we) begin
      mask <= mask | wdata;
    end else if (clr_we) begin
      mask <= mask & ~wdata;
    end
  end

  // Level interrupt while any enabled flag stands
  assign irq = |(status & mask);

endmodule : adc_irq_mask

//--- adc_result_store.sv
// Per-channel result holding registers.
// Assumes end-of-conversion strobe lasts one pclk cycle.
`timescale 1ns/1ps
module adc_result_store #(
  parameter int CHANS = 8,
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Conversion completion
  input wire logic conv_done,
  input wire logic [2:0] conv_chan,
  input wire logic [WIDTH-1:0] conv_value,
  input wire logic [CHANS-1:0] chan_en,
  // Read port
  input wire logic [2:0] rd_chan,
  output logic [WIDTH-1:0] rd_value
);
  import adc_irq_pkg::*;

  // ----------------------------------------
  // Storage array
  // ----------------------------------------
  logic [WIDTH-1:0] result_mem [CHANS]; // One word per channel

  // Capture on completion, only for enabled channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CHANS; i++) begin
        result_mem[i] <= '0;
      end
    end else if (conv_done && chan_en[conv_chan]) begin
      result_mem[conv_chan] <= conv_value;
    end
  end

  // Combinational read; the slave registers it
  assign rd_value = result_mem[rd_chan];

endmodule : adc_result_store

//--- adc_irq_results.sv
// Interrupt control and result holding of an 8-channel converter.
// Assumes the sequencer gives one-cycle completion and overrun strobes.
`timescale 1ns/1ps
module adc_irq_results (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core side
  input wire logic conv_done,
  input wire logic [2:0] conv_chan,
  input wire logic [adc_irq_pkg::RES_WIDTH-1:0] conv_value,
  input wire logic chan_overrun,
  input wire logic global_overrun,
  input wire logic rx_count_end_flag,
  input wire logic rx_both_counts_empty_flag,
  output logic [adc_irq_pkg::NUM_CHAN-1:0] chan_enable,
  output logic reduced_resolution_sel,
  // Interrupt
  output logic irq
);
  import adc_irq_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic access; // Access phase, zero-wait
  logic wr; // Write taking effect
  logic rd; // Read taking effect
  logic wr_irq_set; // Enable register written
  logic wr_irq_clr; // Disable register written
  logic rd_status; // Status register read
  logic rd_latest; // Latest-result register read
  logic addr_ok; // Address maps to a register

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wr_irq_set = wr && (paddr == OFF_IRQ_SET);
  assign wr_irq_clr = wr && (paddr == OFF_IRQ_CLEAR);
  assign rd_status = rd && (paddr == OFF_STATUS);
  assign rd_latest = rd && (paddr == OFF_LATEST);

  // Always ready; no wait states needed
  assign pready = 1'b1;

  // Mapped offsets; anything else answers with an error
  always_comb begin
    addr_ok = 1'b0;
    case (paddr)
      OFF_MODE, OFF_CHAN_ENABLE, OFF_CHAN_DISABLE, OFF_CHAN_VIEW,
      OFF_STATUS, OFF_LATEST, OFF_IRQ_SET, OFF_IRQ_CLEAR,
      OFF_IRQ_VIEW: begin
        addr_ok = 1'b1;
      end
      default: begin
        // Result window, word aligned
        addr_ok = (paddr >= OFF_RESULT0) && (paddr <= OFF_RESULT7) &&
                  (paddr[1:0] == 2'b00);
      end
    endcase
  end
  assign pslverr = access && !addr_ok;

  // ----------------------------------------
  // Mode and channel enables
  // ----------------------------------------
  // Resolution select steers result width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reduced_resolution_sel <= 1'b0;
    end else if (wr && paddr == OFF_MODE) begin
      reduced_resolution_sel <= pwdata[POS_REDUCED_RESOLUTION_SEL];
    end
  end

  // Channel enable set/clear; a per-channel result needs its channel on, the latest result does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_enable <= '0;
    end else if (wr && paddr == OFF_CHAN_ENABLE) begin
      chan_enable <= chan_enable | pwdata[NUM_CHAN-1:0];
    end else if (wr && paddr == OFF_CHAN_DISABLE) begin
      chan_enable <= chan_enable & ~pwdata[NUM_CHAN-1:0];
    end
  end

  // ----------------------------------------
  // Result width
  // ----------------------------------------
  // Reduced mode keeps the low eight bits, upper bits zero
  function automatic logic [RES_WIDTH-1:0] fit_width(
    input logic [RES_WIDTH-1:0] v, input logic low);
    fit_width = low ? {{(RES_WIDTH-RES_WIDTH_LOW){1'b0}},
                       v[RES_WIDTH_LOW-1:0]} : v;
  endfunction : fit_width

  logic [RES_WIDTH-1:0] conv_fit; // Value after width select
  assign conv_fit = fit_width(conv_value, reduced_resolution_sel);

  logic store_ok; // Completion on an enabled channel
  assign store_ok = conv_done && chan_enable[conv_chan];

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic [NUM_CHAN-1:0] conversion_done_flag; // Per-channel done
  logic [NUM_CHAN-1:0] channel_overrun_flag; // Per-channel overrun
  logic result_available_flag; // Latest result waiting
  logic global_overrun_flag; // Any overrun since last read
  logic [RES_WIDTH-1:0] latest_result; // Last converted value
  logic [NUM_CHAN-1:0] chan_hit; // Completion decode

  // One-hot decode of the completing channel
  always_comb begin
    chan_hit = '0;
    if (store_ok) begin
      chan_hit[conv_chan] = 1'b1;
    end
  end

  // Done bit set on completion; dropped when channel disabled,
  // or when its result register is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_hit[i]) begin
          conversion_done_flag[i] <= 1'b1;
        end else if (!chan_enable[i] ||
                     (rd && paddr == OFF_RESULT0 + 8'(4 * i))) begin
          conversion_done_flag[i] <= 1'b0;
        end
      end
    end
  end

  // Overrun flags: set beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_overrun_flag <= '0;
      global_overrun_flag <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_overrun && chan_hit[i]) begin
          channel_overrun_flag[i] <= 1'b1;
        end else if (rd_status) begin
          channel_overrun_flag[i] <= 1'b0;
        end
      end
      if (global_overrun) begin
        global_overrun_flag <= 1'b1;
      end else if (rd_status) begin
        global_overrun_flag <= 1'b0;
      end
    end
  end

  // Ready flag and latest result; a new completion wins over the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_available_flag <= 1'b0;
      latest_result <= '0;
    end else if (conv_done) begin
      result_available_flag <= 1'b1;
      latest_result <= conv_fit;
    end else if (rd_latest) begin
      result_available_flag <= 1'b0;
    end
  end

  // Status word in the shared layout
  logic [NUM_SRC-1:0] status;
  assign status = {rx_both_counts_empty_flag, rx_count_end_flag,
                   global_overrun_flag, result_available_flag,
                   channel_overrun_flag, conversion_done_flag};

  // ----------------------------------------
  // Interrupt mask
  // ----------------------------------------
  logic [NUM_SRC-1:0] irq_enable_view; // Current enables

  // Only the low twenty write bits reach the mask
  adc_irq_mask #(
    .WIDTH(NUM_SRC)
  ) u_mask (
    .pclk(pclk),
    .presetn(presetn),
    .set_we(wr_irq_set),
    .clr_we(wr_irq_clr),
    .wdata(pwdata[NUM_SRC-1:0]),
    .status(status),
    .mask(irq_enable_view),
    .irq(irq)
  );

  // ----------------------------------------
  // Channel results
  // ----------------------------------------
  logic [RES_WIDTH-1:0] channel_result; // Selected channel word
  logic [2:0] rd_chan; // Channel picked by address
  assign rd_chan = 3'((paddr - OFF_RESULT0) >> 2);

  adc_result_store #(
    .CHANS(NUM_CHAN),
    .WIDTH(RES_WIDTH)
  ) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .conv_done(conv_done),
    .conv_chan(conv_chan),
    .conv_value(conv_fit),
    .chan_en(chan_enable),
    .rd_chan(rd_chan),
    .rd_value(channel_result)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] next_prdata; // Word for the current read

  // Unused upper bits read as zero
  always_comb begin
    next_prdata = RST_WORD;
    case (paddr)
      OFF_MODE: next_prdata[POS_REDUCED_RESOLUTION_SEL] = reduced_resolution_sel;
      OFF_CHAN_VIEW: next_prdata[NUM_CHAN-1:0] = chan_enable;
      OFF_STATUS: next_prdata[NUM_SRC-1:0] = status;
      OFF_LATEST: next_prdata[RES_WIDTH-1:0] = latest_result;
      OFF_IRQ_VIEW: next_prdata[NUM_SRC-1:0] = irq_enable_view;
      default: begin
        if (addr_ok && paddr >= OFF_RESULT0) begin
          next_prdata[RES_WIDTH-1:0] = channel_result;
        end
      end
    endcase
  end

  // Data launched in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule : adc_irq_results

//--- adc_irq_results_chk.sv
// Bus-visible checks for the converter interrupt block.
// Sees only the top ports; bound in below.
`timescale 1ns/1ps
module adc_irq_results_chk
  import adc_irq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Converter side
  input wire logic conv_done,
  input wire logic chan_overrun,
  input wire logic global_overrun,
  input wire logic rx_count_end_flag,
  input wire logic rx_both_counts_empty_flag,
  input wire logic irq
);
  logic rd; // Read access edge
  logic wr; // Write access edge
  logic [19:0] m; // Shadow of the mask
  logic ovr_ok; // No overrun since last status read
  logic rdy_ok; // No completion since last latest read
  assign rd = psel && penable && pready && !pwrite;
  assign wr = psel && penable && pready && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow follows set and clear writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m <= '0;
    end else if (wr && paddr == OFF_IRQ_SET) begin
      m <= m | pwdata[19:0];
    end else if (wr && paddr == OFF_IRQ_CLEAR) begin
      m <= m & ~pwdata[19:0];
    end
  end
  // Clean flags; an event wins over a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_ok <= 1'b1;
      rdy_ok <= 1'b1;
    end else begin
      ovr_ok <= (chan_overrun || global_overrun) ? 1'b0 :
        (rd && paddr == OFF_STATUS) ? 1'b1 : ovr_ok;
      rdy_ok <= conv_done ? 1'b0 :
        (rd && paddr == OFF_LATEST) ? 1'b1 : rdy_ok;
    end
  end
  property p_set;
    wr && paddr == OFF_IRQ_SET ##1 !penable ##1 rd && paddr == OFF_IRQ_VIEW
      |-> (prdata[19:0] & $past(pwdata[19:0], 2)) == $past(pwdata[19:0], 2);
  endproperty
  a_set: assert property (p_set) else $error("set bit not seen");
  property p_clr;
    wr && paddr == OFF_IRQ_CLEAR ##1 !penable ##1 rd && paddr == OFF_IRQ_VIEW
      |-> (prdata[19:0] & $past(pwdata[19:0], 2)) == 20'h00000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear bit still seen");
  property p_view;
    rd && paddr == OFF_IRQ_VIEW |-> prdata == {12'h000, m};
  endproperty
  a_view: assert property (p_view) else $error("mask view wrong");
  property p_irq;
    m == 20'h00000 |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq with empty mask");
  property p_res;
    rd && paddr >= OFF_RESULT0 && paddr <= OFF_RESULT7
      |-> prdata[31:10] == 22'h000000;
  endproperty
  a_res: assert property (p_res) else $error("result too wide");
  property p_ovr;
    rd && paddr == OFF_STATUS && ovr_ok |-> {prdata[17], prdata[15:8]} == 9'h000;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not cleared");
  property p_rdy;
    rd && paddr == OFF_STATUS && rdy_ok |-> !prdata[16];
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not cleared");
  property p_rx;
    rd && paddr == OFF_STATUS |-> prdata[19:18] ==
      $past({rx_both_counts_empty_flag, rx_count_end_flag});
  endproperty
  a_rx: assert property (p_rx) else $error("rx bits misplaced");
endmodule : adc_irq_results_chk

bind adc_irq_results adc_irq_results_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .conv_done(conv_done), .chan_overrun(chan_overrun),
  .global_overrun(global_overrun), .rx_count_end_flag(rx_count_end_flag),
  .rx_both_counts_empty_flag(rx_both_counts_empty_flag), .irq(irq)
);

//--- adc_irq_results_test.sv
// Bench for the converter interrupt block.
// Drives APB and converter strobes itself; checker is bound.
`timescale 1ns/1ps
module adc_irq_results_test;
  import adc_irq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, conv_done = 1'b0, chan_overrun = 1'b0;
  logic global_overrun = 1'b0, rx_end = 1'b0, rx_full = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rnd = 32'hADF7D47D, em = 32'h0, prdata;
  logic [2:0] conv_chan = 3'h0;
  logic [RES_WIDTH-1:0] conv_value = 10'h000;
  logic [RES_WIDTH-1:0] r [0:4]; // Random results
  logic pready, pslverr, irq, low_sel;
  logic [NUM_CHAN-1:0] chan_en;
  logic [40:0] note; // Expected {addr, err, data}
  logic [40:0] notes [$];
  int errors = 0, cmp_count = 0;

  adc_irq_results uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_value(conv_value),
    .chan_overrun(chan_overrun), .global_overrun(global_overrun),
    .rx_count_end_flag(rx_end), .rx_both_counts_empty_flag(rx_full),
    .chan_enable(chan_en), .reduced_resolution_sel(low_sel), .irq(irq)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [32:0] seen,
    input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // One transfer, request left up so the next setup may follow at once
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] exp);
    notes.push_back({a, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  // Completion pulse; the value is scrambled afterwards on purpose
  task automatic conv(input logic [2:0] ch, input logic [9:0] v,
    input logic ovr);
    psel <= 1'b0;
    penable <= 1'b0;
    conv_done <= 1'b1;
    conv_chan <= ch;
    conv_value <= v;
    chan_overrun <= ovr;
    global_overrun <= ovr;
    @(posedge pclk);
    conv_done <= 1'b0;
    chan_overrun <= 1'b0;
    global_overrun <= 1'b0;
    conv_value <= ~v;
    @(posedge pclk);
  endtask : conv

  // Irq is combinational, so look mid-cycle
  task automatic see_irq(input logic e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    check("irq", {32'h0, irq}, {32'h0, e});
    @(posedge pclk);
  endtask : see_irq

  initial begin
    forever #5 pclk = ~pclk;
  end

  // Takes the oldest note at every access edge
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      check($sformatf("reg_%h", note[40:33]),
        {pslverr, pwrite ? 32'h0 : prdata}, note[32:0]);
    end
  end

  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_IRQ_VIEW, 32'h0);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CHAN_ENABLE, 32'h0000000F);
    rd(OFF_CHAN_VIEW, 32'h0000000F);
    check("chan_en", {25'h0, chan_en}, 33'h00000000F);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      em = em | {12'h000, rnd[19:0]};
      wr(OFF_IRQ_SET, rnd);
      rd(OFF_IRQ_VIEW, em);
      rnd = lfsr(rnd);
      em = em & ~{12'h000, rnd[19:0]};
      wr(OFF_IRQ_CLEAR, rnd);
      rd(OFF_IRQ_VIEW, em);
    end
    wr(OFF_IRQ_CLEAR, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      r[i] = rnd[9:0];
    end
    conv(3'd2, r[0], 1'b0);
    rd(OFF_STATUS, 32'h00010004);
    rd(OFF_LATEST, {22'h0, r[0]});
    rd(OFF_STATUS, 32'h00000004);
    rd(8'h38, {22'h0, r[0]});
    conv(3'd5, r[1], 1'b0);
    rd(8'h44, 32'h0);
    rd(OFF_LATEST, {22'h0, r[1]});
    conv(3'd3, r[2], 1'b0);
    rd(8'h38, {22'h0, r[0]});
    rd(8'h3C, {22'h0, r[2]});
    wr(OFF_CHAN_DISABLE, 32'h00000004);
    conv(3'd2, r[3], 1'b0);
    rd(8'h38, {22'h0, r[0]});
    rd(OFF_LATEST, {22'h0, r[3]});
    conv(3'd1, r[4], 1'b1);
    rd(OFF_STATUS, 32'h00030202);
    rd(OFF_STATUS, 32'h00010002);
    wr(OFF_IRQ_SET, 32'h00000002);
    see_irq(1'b1);
    rd(8'h34, {22'h0, r[4]});
    see_irq(1'b0);
    wr(OFF_IRQ_SET, 32'h00010000);
    see_irq(1'b1);
    rd(OFF_LATEST, {22'h0, r[4]});
    see_irq(1'b0);
    rx_end <= 1'b1;
    rx_full <= 1'b1;
    wr(OFF_IRQ_SET, 32'h00040000);
    see_irq(1'b1);
    rd(OFF_STATUS, 32'h000C0000);
    wr(OFF_IRQ_CLEAR, 32'hFFFFFFFF);
    see_irq(1'b0);
    wr(OFF_MODE, 32'h00000010);
    rd(OFF_MODE, 32'h00000010);
    check("low_sel", {32'h0, low_sel}, 33'h000000001);
    conv(3'd0, 10'h3A5, 1'b0);
    rd(OFF_RESULT0, 32'h000000A5);
    apb(1'b0, 8'h50, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h08, 32'hFFFFFFFF, {1'b1, 32'h0});
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    conclude();
  end
endmodule : adc_irq_results_test
